// [src/lbo_core.sv]
// Localbuffer access and ownership: register file, reads, ownership test,
// forced update, write filter. Assumes the localbuffer memory answers each
// held request with one lbAck pulse and test units return one testValid.
//
// Added by the designer: the address map and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module lbo_core
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic wbWe,
   input wire logic [lbo_pkg::WB_ADR_W-1:0] wbAdr,
   input wire logic [3:0] wbSel,
   input wire logic [31:0] wbDatW,
   output logic [31:0] wbDatR,
   output logic wbAck,
   input wire logic fragValid,
   input wire lbo_pkg::lbo_frag_t fragIn,
   output logic fragReady,
   output logic destValid,
   output lbo_pkg::lbo_pixel_t destPixel,
   input wire logic testValid,
   input wire logic testPass,
   output logic fragDone,
   output logic fragWritten,
   output logic lbReq,
   output logic lbReqWe,
   output logic [lbo_pkg::ADDR_W-1:0] lbReqAddr,
   output logic [lbo_pkg::DATA_W-1:0] lbReqData,
   input wire logic lbAck,
   input wire logic [lbo_pkg::DATA_W-1:0] lbRspData
);
   import lbo_pkg::*;

   // ==========================================
   // Helpers
   function automatic int regIndex(input logic [WB_ADR_W-1:0] a);
      return int'(a >> 2);
   endfunction

   function automatic logic [31:0] regMask(input int idx);
      case (idx)
         regIndex(OFS_READ_CTRL): return 32'($bits(lbo_read_ctrl_t)'('1));
         regIndex(OFS_WRITE_EN): return 32'h0000_0001;
         regIndex(OFS_READ_FMT), regIndex(OFS_WRITE_FMT): return 32'($bits(lbo_layout_t)'('1));
         regIndex(OFS_SRC_OFFSET), regIndex(OFS_WIN_BASE): return 32'(ADDR_W'('1));
         regIndex(OFS_OWN_CTRL): return 32'($bits(lbo_own_ctrl_t)'('1));
         regIndex(OFS_STENCIL): return 32'(STENCIL_W'('1));
         default: return 32'hffff_ffff;
      endcase
   endfunction

   function automatic logic [31:0] fieldGet(input logic [DATA_W-1:0] raw, input int pos, input int w);
      logic [DATA_W-1:0] s;
      s = raw >> pos;
      return s[31:0] & ((32'h1 << w) - 32'h1);
   endfunction

   function automatic logic [DATA_W-1:0] fieldPut(input logic [DATA_W-1:0] raw, input int pos,
      input int w, input logic [31:0] v);
      logic [DATA_W-1:0] m;
      m = ((DATA_W'(1) << w) - DATA_W'(1)) << pos;
      return (raw & ~m) | ((DATA_W'(v) << pos) & m);
   endfunction

   function automatic int depthBits(input logic [1:0] c);
      return (c == 2'h0) ? DEPTH_W0 : (c == 2'h1) ? DEPTH_W1 : DEPTH_W2;
   endfunction

   function automatic int fieldPos(input logic [3:0] p);
      return POS_BASE + POS_STEP * int'(p);
   endfunction

   // Storage word to internal pixel
   function automatic lbo_pixel_t unpackPixel(input logic [DATA_W-1:0] raw, input lbo_layout_t f,
      input logic [1:0] kind);
      lbo_pixel_t p;
      p = '0;
      if (f.compact32)
      begin
         p.depth = fieldGet(raw, 0, CMP_DEPTH_W);
         p.stencil = 8'(fieldGet(raw, CMP_STEN_POS, CMP_STEN_W));
         p.frame_counter_value = 8'(fieldGet(raw, CMP_FC_POS, CMP_FC_W));
         p.ownerId = ID_W'(fieldGet(raw, CMP_ID_POS, CMP_ID_W));
      end
      else
      begin
         p.depth = fieldGet(raw, 0, depthBits(f.depthWidth));
         p.stencil = 8'(fieldGet(raw, fieldPos({1'b0, f.stencilPos}), NIBBLE * int'(f.stencilWidth)));
         p.frame_counter_value = 8'(fieldGet(raw, fieldPos({1'b0, f.frameCountPos}),
            NIBBLE * int'(f.frameCountWidth)));
         p.ownerId = ID_W'(fieldGet(raw, fieldPos(f.ownerIdPos), ID_W * int'(f.ownerIdWidth)));
      end
      if (kind == KIND_STENCIL)
      begin
         p.depth = '0;
         p.frame_counter_value = '0;
         p.ownerId = '0;
      end
      else if (kind == KIND_DEPTH)
      begin
         p.stencil = '0;
         p.frame_counter_value = '0;
         p.ownerId = '0;
      end
      return p;
   endfunction

   // Internal pixel to storage word
   function automatic logic [DATA_W-1:0] packPixel(input lbo_pixel_t p, input lbo_layout_t f);
      logic [DATA_W-1:0] r;
      r = '0;
      if (f.compact32)
      begin
         r = fieldPut(r, 0, CMP_DEPTH_W, p.depth);
         r = fieldPut(r, CMP_STEN_POS, CMP_STEN_W, 32'(p.stencil));
         r = fieldPut(r, CMP_FC_POS, CMP_FC_W, 32'(p.frame_counter_value));
         r = fieldPut(r, CMP_ID_POS, CMP_ID_W, 32'(p.ownerId));
      end
      else
      begin
         r = fieldPut(r, 0, depthBits(f.depthWidth), p.depth);
         r = fieldPut(r, fieldPos({1'b0, f.stencilPos}), NIBBLE * int'(f.stencilWidth), 32'(p.stencil));
         r = fieldPut(r, fieldPos({1'b0, f.frameCountPos}), NIBBLE * int'(f.frameCountWidth),
            32'(p.frame_counter_value));
         r = fieldPut(r, fieldPos(f.ownerIdPos), ID_W * int'(f.ownerIdWidth), 32'(p.ownerId));
      end
      return r;
   endfunction

   // ==========================================
   // Register file over Wishbone
   logic [31:0] regs_q [NUM_RW];
   logic [31:0] regs_d [NUM_RW];
   logic ack_q, ack_d;
   logic [31:0] rdat_q, rdat_d;
   logic [15:0] discard_q, discard_d;
   lbo_state_t state_q, state_d;
   int idx;
   lbo_read_ctrl_t readCtrl;
   lbo_layout_t readFmt, writeFmt;
   lbo_own_ctrl_t ownCtrl;
   lbo_status_t status;
   logic writeEnable;

   assign readCtrl = lbo_read_ctrl_t'(regs_q[regIndex(OFS_READ_CTRL)][$bits(lbo_read_ctrl_t)-1:0]);
   assign readFmt = lbo_layout_t'(regs_q[regIndex(OFS_READ_FMT)][$bits(lbo_layout_t)-1:0]);
   assign writeFmt = lbo_layout_t'(regs_q[regIndex(OFS_WRITE_FMT)][$bits(lbo_layout_t)-1:0]);
   assign ownCtrl = lbo_own_ctrl_t'(regs_q[regIndex(OFS_OWN_CTRL)][$bits(lbo_own_ctrl_t)-1:0]);
   assign writeEnable = regs_q[regIndex(OFS_WRITE_EN)][0];
   assign wbAck = ack_q;
   assign wbDatR = rdat_q;

   // Status word shows the engine's own progress
   always_comb
   begin
      status = '0;
      status.discardCount = discard_q;
      status.fsmState = state_q;
      status.busy = (state_q != ST_IDLE);
   end

   // Single-wait-state slave: ack one edge after the strobe, write at the ack edge
   always_comb
   begin
      idx = regIndex(wbAdr);
      ack_d = wbCyc && wbStb && !ack_q;
      rdat_d = rdat_q;
      regs_d = regs_q;
      if (ack_d)
         rdat_d = (wbAdr == OFS_STATUS) ? 32'(status) : (idx < NUM_RW) ? regs_q[idx] : '0;
      if (wbCyc && wbStb && wbWe && ack_q && idx < NUM_RW)
      begin
         for (int b = 0; b < 4; b++)
            if (wbSel[b])
               regs_d[idx][b*8 +: 8] = wbDatW[b*8 +: 8];
         regs_d[idx] = regs_d[idx] & regMask(idx);
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         ack_q <= 1'b0;
         rdat_q <= '0;
         for (int i = 0; i < NUM_RW; i++)
            regs_q[i] <= '0;
      end
      else
      begin
         ack_q <= ack_d;
         rdat_q <= rdat_d;
         regs_q <= regs_d;
      end
   end

   // ==========================================
   // Fragment engine
   logic [ADDR_W-1:0] genDst, genSrc;
   lbo_frag_t frag_q, frag_d;
   logic [ADDR_W-1:0] dst_q, dst_d, src_q, src_d, addr_q, addr_d;
   logic [DATA_W-1:0] dRaw_q, dRaw_d, sRaw_q, sRaw_d, wdat_q, wdat_d;
   logic done_q, done_d, wrote_q, wrote_d, own_q, own_d, same_q, same_d;
   lbo_pixel_t destPix, srcPix, regPix, newPix;
   logic ownPass, allow, doWrite, stale;

   lbo_addr_gen uAddr
   (
      .ctrl(readCtrl),
      .base(regs_q[regIndex(OFS_WIN_BASE)][ADDR_W-1:0]),
      .offset(regs_q[regIndex(OFS_SRC_OFFSET)][ADDR_W-1:0]),
      .x(fragIn.x),
      .y(fragIn.y),
      .dstAddr(genDst),
      .srcAddr(genSrc)
   );

   // Decode stored data; fast-clear planes substitute stale depth and stencil
   always_comb
   begin
      destPix = unpackPixel(dRaw_q, readFmt, readCtrl.readDataKind);
      srcPix = unpackPixel(sRaw_q, readFmt, KIND_NORMAL);
      stale = destPix.frame_counter_value != ownCtrl.frameCounterValue;
      if (ownCtrl.depthFastClearPlane && stale)
         destPix.depth = regs_q[regIndex(OFS_DEPTH)];
      if (ownCtrl.stencilFastClearPlane && stale)
         destPix.stencil = regs_q[regIndex(OFS_STENCIL)][STENCIL_W-1:0];
      regPix = '{depth: regs_q[regIndex(OFS_DEPTH)], stencil: regs_q[regIndex(OFS_STENCIL)][STENCIL_W-1:0],
         frame_counter_value: ownCtrl.frameCounterValue, ownerId: ownCtrl.graphicOwnerId};
   end

   // Ownership test and write decision
   always_comb
   begin
      ownPass = 1'b1;
      if (ownCtrl.unitEnable)
         case (ownCtrl.ownershipCompareSel)
            CMP_ALWAYS: ownPass = 1'b1;
            CMP_NEVER: ownPass = 1'b0;
            CMP_EQUAL: ownPass = destPix.ownerId == ownCtrl.graphicOwnerId;
            default: ownPass = destPix.ownerId != ownCtrl.graphicOwnerId;
         endcase
      if (ownCtrl.forceBufferUpdate)
         newPix = ownCtrl.updateSourceSel ? srcPix : regPix;
      else
         newPix = '{depth: frag_q.depth, stencil: frag_q.stencil,
            frame_counter_value: ownCtrl.frameCounterValue, ownerId: destPix.ownerId};
      allow = writeEnable && (ownCtrl.forceBufferUpdate || (ownPass && testPass));
      doWrite = allow && (ownCtrl.noWriteSkip || !readCtrl.destReadEnable
         || newPix != destPix);
   end

   // Sequencer: destination read, source read, test, write
   always_comb
   begin
      state_d = state_q;
      frag_d = frag_q;
      dst_d = dst_q;
      src_d = src_q;
      addr_d = addr_q;
      dRaw_d = dRaw_q;
      sRaw_d = sRaw_q;
      wdat_d = wdat_q;
      own_d = own_q;
      same_d = same_q;
      discard_d = discard_q;
      done_d = 1'b0;
      wrote_d = 1'b0;
      case (state_q)
         ST_IDLE:
            if (fragValid)
            begin
               frag_d = fragIn;
               dst_d = genDst;
               src_d = genSrc;
               dRaw_d = '0;
               sRaw_d = '0;
               addr_d = readCtrl.destReadEnable ? genDst : genSrc;
               state_d = readCtrl.destReadEnable ? ST_RDST : readCtrl.srcReadEnable ? ST_RSRC : ST_TEST;
            end
         ST_RDST:
            if (lbAck)
            begin
               dRaw_d = lbRspData;
               addr_d = src_q;
               state_d = readCtrl.srcReadEnable ? ST_RSRC : ST_TEST;
            end
         ST_RSRC:
            if (lbAck)
            begin
               sRaw_d = lbRspData;
               state_d = ST_TEST;
            end
         ST_TEST:
            if (testValid)
            begin
               own_d = ownPass || ownCtrl.forceBufferUpdate;
               same_d = newPix == destPix;
               wdat_d = packPixel(newPix, writeFmt);
               addr_d = dst_q;
               if (doWrite)
                  state_d = ST_WRITE;
               else
               begin
                  done_d = 1'b1;
                  if (!allow)
                     discard_d = discard_q + 16'h1;
                  state_d = ST_IDLE;
               end
            end
         ST_WRITE:
            if (lbAck)
            begin
               done_d = 1'b1;
               wrote_d = 1'b1;
               state_d = ST_IDLE;
            end
         default: state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         state_q <= ST_IDLE;
         frag_q <= '0;
         dst_q <= '0;
         src_q <= '0;
         addr_q <= '0;
         dRaw_q <= '0;
         sRaw_q <= '0;
         wdat_q <= '0;
         own_q <= 1'b0;
         same_q <= 1'b0;
         discard_q <= '0;
         done_q <= 1'b0;
         wrote_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         frag_q <= frag_d;
         dst_q <= dst_d;
         src_q <= src_d;
         addr_q <= addr_d;
         dRaw_q <= dRaw_d;
         sRaw_q <= sRaw_d;
         wdat_q <= wdat_d;
         own_q <= own_d;
         same_q <= same_d;
         discard_q <= discard_d;
         done_q <= done_d;
         wrote_q <= wrote_d;
      end
   end

   // Memory and test-unit handshakes
   assign fragReady = (state_q == ST_IDLE);
   assign lbReq = (state_q == ST_RDST) || (state_q == ST_RSRC) || (state_q == ST_WRITE);
   assign lbReqWe = (state_q == ST_WRITE);
   assign lbReqAddr = addr_q;
   assign lbReqData = wdat_q;
   assign destValid = (state_q == ST_TEST);
   assign destPixel = destPix;
   assign fragDone = done_q;
   assign fragWritten = wrote_q;

   // ==========================================
   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   bus_ack_pulse_a: assert property (wbAck |=> !wbAck) else $error("ack held two cycles");
   write_gate_a: assert property (lbReq && lbReqWe |-> writeEnable)
      else $error("write without write enable");
   owner_discard_a: assert property (lbReq && lbReqWe |-> own_q)
      else $error("write after failed ownership");
   unit_off_a: assert property (destValid && !ownCtrl.unitEnable |-> ownPass)
      else $error("disabled unit blocked fragment");
   never_pass_a: assert property (destValid && ownCtrl.unitEnable && ownCtrl.ownershipCompareSel == CMP_NEVER
      |-> !ownPass) else $error("always-fail sense passed");
   skip_same_a: assert property (lbReq && lbReqWe |-> !same_q || ownCtrl.noWriteSkip || !readCtrl.destReadEnable)
      else $error("unchanged data written");
   src_offset_a: assert property (state_q == ST_RSRC |-> lbReqAddr == src_q && src_q == dst_q
      + regs_q[regIndex(OFS_SRC_OFFSET)][ADDR_W-1:0]) else $error("bad source address");
   dest_enable_a: assert property (state_q == ST_RDST |-> readCtrl.destReadEnable)
      else $error("destination read while disabled");
   write_done_a: assert property (lbReq && lbReqWe && lbAck |=> fragDone && fragWritten)
      else $error("write completion not reported");

   write_seen_c: cover property (lbReq && lbReqWe && lbAck);
   copy_seen_c: cover property (state_q == ST_RSRC ##1 state_q == ST_TEST);
   discard_seen_c: cover property (fragDone && !fragWritten);

endmodule
`default_nettype wire

// [src/lbo_pkg.sv]
// Shared types and constants for the localbuffer access and ownership block.
// Assumes a 32-bit classic Wishbone register bus and a 64-bit localbuffer word.
package lbo_pkg;

   // ==========================================
   // Sizes
   localparam int ADDR_W = 24;
   localparam int DATA_W = 64;
   localparam int WB_ADR_W = 8;
   localparam int ID_W = 4;
   localparam int TILE_W = 2;

   // ==========================================
   // Register byte offsets
   localparam logic [WB_ADR_W-1:0] OFS_READ_CTRL = 8'h00;
   localparam logic [WB_ADR_W-1:0] OFS_WRITE_EN = 8'h04;
   localparam logic [WB_ADR_W-1:0] OFS_READ_FMT = 8'h08;
   localparam logic [WB_ADR_W-1:0] OFS_WRITE_FMT = 8'h0c;
   localparam logic [WB_ADR_W-1:0] OFS_SRC_OFFSET = 8'h10;
   localparam logic [WB_ADR_W-1:0] OFS_WIN_BASE = 8'h14;
   localparam logic [WB_ADR_W-1:0] OFS_OWN_CTRL = 8'h18;
   localparam logic [WB_ADR_W-1:0] OFS_DEPTH = 8'h1c;
   localparam logic [WB_ADR_W-1:0] OFS_STENCIL = 8'h20;
   localparam logic [WB_ADR_W-1:0] OFS_STATUS = 8'h24;
   localparam int NUM_RW = 9;
   localparam int STENCIL_W = 8;

   // ==========================================
   // Field codes and layout constants
   localparam logic [3:0] PP_SHIFT_BASE = 4'h4;
   localparam int POS_BASE = 16;
   localparam int POS_STEP = 4;
   localparam int NIBBLE = 4;
   localparam int DEPTH_W0 = 16;
   localparam int DEPTH_W1 = 24;
   localparam int DEPTH_W2 = 32;
   localparam int CMP_DEPTH_W = 24;
   localparam int CMP_STEN_POS = 24;
   localparam int CMP_STEN_W = 1;
   localparam int CMP_FC_POS = 25;
   localparam int CMP_FC_W = 4;
   localparam int CMP_ID_POS = 29;
   localparam int CMP_ID_W = 3;
   localparam logic [1:0] KIND_NORMAL = 2'h0;
   localparam logic [1:0] KIND_STENCIL = 2'h1;
   localparam logic [1:0] KIND_DEPTH = 2'h2;
   localparam logic [1:0] CMP_ALWAYS = 2'h0;
   localparam logic [1:0] CMP_NEVER = 2'h1;
   localparam logic [1:0] CMP_EQUAL = 2'h2;
   localparam logic [1:0] CMP_NOT_EQUAL = 2'h3;

   // ==========================================
   // Register views
   typedef struct packed {
      logic [2:0] textureTileCode;
      logic [1:0] lineInterleaveStep;
      logic tiledEnable;
      logic originSelect;     // 1: top left, 0: bottom left
      logic [1:0] readDataKind;
      logic destReadEnable;
      logic srcReadEnable;
      logic [2:0] widthPartialProductC;
      logic [2:0] widthPartialProductB;
      logic [2:0] widthPartialProductA;
   } lbo_read_ctrl_t;

   typedef struct packed {
      logic compact32;
      logic [3:0] ownerIdPos;
      logic ownerIdWidth;
      logic [2:0] frameCountPos;
      logic [1:0] frameCountWidth;
      logic [2:0] stencilPos;
      logic [1:0] stencilWidth;
      logic [1:0] depthWidth;
   } lbo_layout_t;

   typedef struct packed {
      logic [7:0] frameCounterValue;
      logic stencilFastClearPlane;
      logic depthFastClearPlane;
      logic noWriteSkip;
      logic updateSourceSel;  // 1: localbuffer source data, 0: registers
      logic forceBufferUpdate;
      logic [1:0] ownershipCompareSel;
      logic [ID_W-1:0] graphicOwnerId;
      logic unitEnable;
   } lbo_own_ctrl_t;

   typedef struct packed {
      logic [11:0] rsvd;
      logic [15:0] discardCount;
      logic [2:0] fsmState;
      logic busy;
   } lbo_status_t;

   // Internal pixel representation, independent of storage format
   typedef struct packed {
      logic [31:0] depth;
      logic [7:0] stencil;
      logic [7:0] frame_counter_value;
      logic [ID_W-1:0] ownerId;
   } lbo_pixel_t;

   typedef struct packed {
      logic [11:0] x;
      logic [11:0] y;
      logic [31:0] depth;
      logic [7:0] stencil;
   } lbo_frag_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_RDST = 3'h1,
      ST_RSRC = 3'h3,
      ST_TEST = 3'h2,
      ST_WRITE = 3'h6
   } lbo_state_t;

endpackage

// [src/lbo_addr_gen.sv]
// Localbuffer address generator: line width, origin, interleave, tiling.
// Assumes stable inputs from registered state; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module lbo_addr_gen
(
   input wire lbo_pkg::lbo_read_ctrl_t ctrl,
   input wire logic [lbo_pkg::ADDR_W-1:0] base,
   input wire logic [lbo_pkg::ADDR_W-1:0] offset,
   input wire logic [11:0] x,
   input wire logic [11:0] y,
   output logic [lbo_pkg::ADDR_W-1:0] dstAddr,
   output logic [lbo_pkg::ADDR_W-1:0] srcAddr
);
   import lbo_pkg::*;

   // ==========================================
   // Width term: zero code gives no term, else one power of two
   function automatic logic [ADDR_W-1:0] ppTerm(input logic [2:0] p);
      if (p == 3'h0)
         return '0;
      return ADDR_W'(1) << ({1'b0, p} + PP_SHIFT_BASE);
   endfunction

   logic [ADDR_W-1:0] lineWidth;
   logic [ADDR_W-1:0] rowOfs;
   logic [ADDR_W-1:0] linear;
   logic [TILE_W-1:0] tileMix;

   // ==========================================
   // Address arithmetic
   always_comb
   begin
      lineWidth = ppTerm(ctrl.widthPartialProductA) + ppTerm(ctrl.widthPartialProductB)
         + ppTerm(ctrl.widthPartialProductC);
      rowOfs = ADDR_W'(y >> ctrl.lineInterleaveStep) * lineWidth;
      if (ctrl.originSelect)
         linear = base + rowOfs + ADDR_W'(x);
      else
         linear = base - rowOfs + ADDR_W'(x);
      // Swizzle only low bits so tiles stay inside the current window
      tileMix = y[TILE_W-1:0] ^ ctrl.textureTileCode[TILE_W-1:0];
      dstAddr = linear;
      if (ctrl.tiledEnable)
         dstAddr[TILE_W-1:0] = linear[TILE_W-1:0] ^ tileMix;
      srcAddr = dstAddr + offset;
   end

endmodule
`default_nettype wire

// [verif/lbo_mem_model.sv]
// Behavioural localbuffer memory on the block's memory port.
// Assumes lbReq is held until lbAck; lat adds wait cycles.
`timescale 1ns/1ps
`default_nettype none
module lbo_mem_model
(
   input wire logic core_clk,
   input wire logic [1:0] lat,
   input wire logic lbReq,
   input wire logic lbReqWe,
   input wire logic [lbo_pkg::ADDR_W-1:0] lbReqAddr,
   input wire logic [lbo_pkg::DATA_W-1:0] lbReqData,
   output logic lbAck,
   output logic [lbo_pkg::DATA_W-1:0] lbRspData
);
   import lbo_pkg::*;
   logic [DATA_W-1:0] mem [16];
   logic [1:0] cnt;
   // ==========
   // Answer after lat waits; data toggles while not valid
   // One process drives every output, so the bench never sees two drivers
   always @(posedge core_clk)
   begin
      lbAck <= 1'b0;
      lbRspData <= ~lbRspData;
      cnt <= 2'h0;
      if (lbReq && !lbAck)
      begin
         cnt <= cnt + 2'h1;
         if (cnt == lat)
         begin
            lbAck <= 1'b1;
            if (lbReqWe) mem[lbReqAddr[3:0]] <= lbReqData;
            else lbRspData <= mem[lbReqAddr[3:0]];
         end
      end
   end
endmodule
`default_nettype wire

// [verif/localbuffer_access_and_ownership_bench.sv]
// Self-checking bench for lbo_core with a behavioural memory.
// Assumes the offsets and field codes of lbo_pkg.
`timescale 1ns/1ps
`default_nettype none
module localbuffer_access_and_ownership_bench;
   import lbo_pkg::*;
   logic core_clk, nrst, wbCyc, wbStb, wbWe, wbAck, fragValid, fragReady, destValid;
   logic testValid, testPass, fragDone, fragWritten, lbReq, lbReqWe, lbAck;
   logic [7:0] wbAdr;
   logic [3:0] wbSel;
   logic [31:0] wbDatW, wbDatR, r;
   logic [1:0] lat;
   logic [ADDR_W-1:0] lbReqAddr;
   logic [DATA_W-1:0] lbReqData, lbRspData;
   lbo_frag_t fragIn;
   lbo_pixel_t destPixel;
   int nMismatch = 0;
   int testsRun = 0;
   lbo_core i_lbo_core (.*);
   lbo_mem_model i_lbo_mem_model (.*);
   // ==========
   // Shared tasks
   task automatic chk(input string n, input logic [63:0] s, e);
      testsRun++;
      if (s !== e)
      begin
         nMismatch++;
         $display("FAIL %s expected %h seen %h", n, e, s);
      end
   endtask
   task final_report;
      $display("comparisons %0d mismatches %0d", testsRun, nMismatch);
      if (nMismatch == 0 && testsRun > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Wishbone classic cycle, held until ack is sampled
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= a;
      wbDatW <= d;
      do @(posedge core_clk); while (wbAck !== 1'b1);
      r = wbDatR;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      @(posedge core_clk);
   endtask
   // One fragment at pixel 0,0; test units always pass
   task automatic frag(input logic [15:0] dp, input logic ex);
      fragValid <= 1'b1;
      fragIn <= '{12'h0, 12'h0, {16'h0, dp}, 8'h0};
      @(posedge core_clk);
      fragValid <= 1'b0;
      do @(posedge core_clk); while (destValid !== 1'b1);
      chk("owner id", destPixel.ownerId, 4'h5);
      testValid <= 1'b1;
      @(posedge core_clk);
      testValid <= 1'b0;
      do @(posedge core_clk); while (fragDone !== 1'b1);
      chk("written", fragWritten, ex);
   endtask
   // ==========
   // Scenarios
   task t_regs;
      wb(1'b1, OFS_WIN_BASE, 32'hff123450);
      wb(1'b0, OFS_WIN_BASE, 32'h0);
      chk("base", r, 32'h00123450);
      wb(1'b1, OFS_WIN_BASE, 32'h0);
      wb(1'b1, OFS_SRC_OFFSET, 32'hfffffffe);
      wb(1'b0, OFS_SRC_OFFSET, 32'h0);
      chk("offset", r, 32'h00fffffe);
      wb(1'b0, 8'h28, 32'h0);
      chk("unmapped", r, 32'h0);
   endtask
   // Every compare sense against stored id 5, window id 5 and 3
   task t_owner;
      int i;
      logic e;
      wb(1'b1, OFS_READ_FMT, 32'h1000);
      wb(1'b1, OFS_WRITE_FMT, 32'h1000);
      wb(1'b1, OFS_READ_CTRL, 32'h400);
      wb(1'b1, OFS_WRITE_EN, 32'h1);
      for (i = 0; i < 8; i++)
      begin
         e = (i[1:0] == 2'h0) || (i[1] && (i[0] == i[2]));
         wb(1'b1, OFS_OWN_CTRL, {25'h0, i[1:0], i[2] ? 4'h3 : 4'h5, 1'b1});
         frag(16'h100 + 16'(i), e);
      end
      chk("stored", i_lbo_mem_model.mem[0][19:0], 20'h50107);
   endtask
   // Filtering, override, disabled unit, writes off; memory slow
   task t_filter;
      lat <= 2'h2;
      wb(1'b1, OFS_OWN_CTRL, 32'h1);
      frag(16'h77, 1'b1);
      frag(16'h77, 1'b0);
      wb(1'b1, OFS_OWN_CTRL, 32'h201);
      frag(16'h77, 1'b1);
      wb(1'b1, OFS_OWN_CTRL, 32'h20);
      frag(16'h88, 1'b1);
      wb(1'b1, OFS_WRITE_EN, 32'h0);
      frag(16'h99, 1'b0);
   endtask
   initial forever #2.5 core_clk = ~core_clk;
   // ==========
   // Main sequence
   initial
   begin
      core_clk = 1'b0;
      {nrst, wbCyc, wbStb, wbWe, fragValid, testValid, lat} = '0;
      {wbAdr, wbDatW, fragIn} = '0;
      wbSel = 4'hf;
      testPass = 1'b1;
      i_lbo_mem_model.mem[0] = 64'h50000;
      repeat (10) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      t_regs;
      t_owner;
      t_filter;
      final_report;
   end
   // Hang guard, far beyond the few hundred cycles needed
   initial
   begin
      repeat (20000) @(posedge core_clk);
      nMismatch++;
      final_report;
   end
endmodule
`default_nettype wire
